/* File: design/gst_consts.svh */
`ifndef GST_CONSTS_SVH
`define GST_CONSTS_SVH

// Register word indexes; the byte address is four times the index.
`define GST_IDX_CTRL       3'h0
`define GST_IDX_GATE       3'h1
`define GST_IDX_COUNT_LOW  3'h2
`define GST_IDX_COUNT_HIGH 3'h3
`define GST_IDX_STATUS     3'h4
`define GST_IDX_MASK       3'h5

// Control register fields.
`define GST_CTRL_ON        0
`define GST_CTRL_SYNC_DIS  2
`define GST_CTRL_PRE_LO    4
`define GST_CTRL_PRE_HI    5
`define GST_CTRL_SRC_LO    6
`define GST_CTRL_SRC_HI    7

// Gate control register fields.
`define GST_GATE_SEL       4
`define GST_GATE_POL       6
`define GST_GATE_EN        7

// Status and mask fields.
`define GST_STAT_OVF       0

// Reset values and counts.
`define GST_CTRL_RESET     6'h00
`define GST_GATE_RESET     3'h0
`define GST_COUNT_RESET    16'h0000
`define GST_COUNT_MAX      16'hffff
`define GST_INSTR_LAST     2'h3
`define GST_PRE_ZERO       3'h0
`define GST_RDATA_ZERO     32'h0000_0000

`endif

/* File: design/gst_pkg.sv */
package gst_pkg;

    typedef enum logic [1:0] {
        GST_SRC_INSTR  = 2'b00,
        GST_SRC_SYSTEM = 2'b01,
        GST_SRC_EXT    = 2'b10,
        GST_SRC_LFOSC  = 2'b11
    } gst_src_t;

    typedef struct packed {
        logic       on;
        logic       sync_dis;
        logic [1:0] prescale;
        gst_src_t   source;
    } gst_ctrl_t;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic source_sel;
    } gst_gate_t;

endpackage : gst_pkg

/* File: design/gst_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gst_consts.svh"

module gst_timer (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Avalon-MM slave
    input  wire logic [2:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Pins and neighbouring logic
    input  wire logic        i_external_clock_pin,
    input  wire logic        i_gate_pin,
    input  wire logic        i_low_freq_internal_osc,
    input  wire logic        i_byte_timer_wrap_pulse,
    input  wire logic        i_sleep,
    // Events
    output logic             o_irq,
    output logic             o_wake
);

    logic [1:0]        rst_sync_reg;
    logic              rst_n;
    gst_pkg::gst_ctrl_t ctrl_reg;
    gst_pkg::gst_gate_t gate_reg;
    logic [15:0]       count_reg;
    logic [15:0]       count_next;
    logic [2:0]        pre_reg;
    logic [1:0]        instr_reg;
    logic [1:0]        ext_sync_reg;
    logic [1:0]        lfo_sync_reg;
    logic [1:0]        gpin_sync_reg;
    logic              ext_prev_reg;
    logic              lfo_prev_reg;
    logic              ext_step_reg;
    logic              armed_reg;
    logic              status_reg;
    logic              mask_reg;
    logic              wait_reg;
    logic [31:0]       rdata_reg;
    logic              irq_reg;
    logic              wake_reg;
    logic              accept;
    logic              take_req;
    logic              wr_ctrl;
    logic              wr_gate;
    logic              wr_low;
    logic              wr_high;
    logic              cnt_wr;
    logic              rd_status;
    logic              instr_tick;
    logic              ext_rise;
    logic              ext_fall;
    logic              lfo_rise;
    logic              src_tick;
    logic              gate_src;
    logic              gate_active;
    logic              run;
    logic [2:0]        pre_mask;
    logic              pre_done;
    logic              inc;
    logic              ovf;
    logic [31:0]       rdata_next;
    logic              status_clr;
    logic              sys_full;

    // Reset is released through two flops so every flop leaves reset on the same edge.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers; only the second stage is ever looked at.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_reg  <= 2'h0;
            lfo_sync_reg  <= 2'h0;
            gpin_sync_reg <= 2'h0;
            ext_prev_reg  <= 1'b0;
            lfo_prev_reg  <= 1'b0;
        end else begin
            ext_sync_reg  <= {ext_sync_reg[0], i_external_clock_pin};
            lfo_sync_reg  <= {lfo_sync_reg[0], i_low_freq_internal_osc};
            gpin_sync_reg <= {gpin_sync_reg[0], i_gate_pin};
            ext_prev_reg  <= ext_sync_reg[1];
            lfo_prev_reg  <= lfo_sync_reg[1];
        end
    end

    assign ext_rise = ext_sync_reg[1] && !ext_prev_reg;
    assign ext_fall = !ext_sync_reg[1] && ext_prev_reg;
    assign lfo_rise = lfo_sync_reg[1] && !lfo_prev_reg;

    // Instruction cycle is the system clock divided by four.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg <= 2'h0;
        end else begin
            instr_reg <= instr_reg + 2'h1;
        end
    end
    assign instr_tick = (instr_reg == `GST_INSTR_LAST);

    // Synchronous mode holds an external edge until the next instruction phase, so the
    // count steps on the processor's phase clock; asynchronous mode takes the edge at
    // once. Changing modes with an edge pending can drop or add one step, which is
    // accepted rather than guarded against. Synchronous external counting stops in sleep; the phase counter runs on.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_step_reg <= 1'b0;
        end else if (ctrl_reg.sync_dis || cnt_wr || !ctrl_reg.on) begin
            ext_step_reg <= 1'b0;
        end else if (instr_tick) begin
            ext_step_reg <= ext_rise && armed_reg;
        end else if (ext_rise && armed_reg) begin
            ext_step_reg <= 1'b1;
        end
    end

    // A falling edge must be seen before the first counted rising edge.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (!ctrl_reg.on || cnt_wr) begin
            armed_reg <= 1'b0;
        end else if (ext_fall) begin
            armed_reg <= 1'b1;
        end
    end

    // Clock source selection.
    always_comb begin
        unique case (ctrl_reg.source)
            gst_pkg::GST_SRC_INSTR:  src_tick = instr_tick && !i_sleep;
            gst_pkg::GST_SRC_SYSTEM: src_tick = !i_sleep;
            gst_pkg::GST_SRC_EXT:    src_tick = ctrl_reg.sync_dis ?
                                                (ext_rise && armed_reg) :
                                                (ext_step_reg && instr_tick && !i_sleep);
            gst_pkg::GST_SRC_LFOSC:  src_tick = lfo_rise;
        endcase
    end

    // Gate source and polarity. The wrap pulse is a one-cycle rising pulse.
    assign gate_src    = gate_reg.source_sel ? i_byte_timer_wrap_pulse : gpin_sync_reg[1];
    assign gate_active = (gate_src == gate_reg.polarity);
    assign run         = ctrl_reg.on && (!gate_reg.enable || gate_active);

    // Prescaler divides source ticks by 1, 2, 4 or 8.
    always_comb begin
        unique case (ctrl_reg.prescale)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            2'h3: pre_mask = 3'h7;
        endcase
    end
    assign pre_done = ((pre_reg & pre_mask) == pre_mask);
    assign inc      = run && src_tick && pre_done && !cnt_wr;
    assign ovf      = inc && (count_reg == `GST_COUNT_MAX);

    // Hidden prescale counter, cleared by any write to the count.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= `GST_PRE_ZERO;
        end else if (cnt_wr || !ctrl_reg.on) begin
            pre_reg <= `GST_PRE_ZERO;
        end else if (run && src_tick) begin
            pre_reg <= pre_done ? `GST_PRE_ZERO : pre_reg + 3'h1;
        end
    end

    // Bus decode. A request is answered one cycle after it appears.
    assign take_req  = (i_avs_read || i_avs_write) && wait_reg;
    assign accept    = (i_avs_read || i_avs_write) && !wait_reg;
    assign wr_ctrl   = accept && i_avs_write && (i_avs_address == `GST_IDX_CTRL) && i_avs_byteenable[0];
    assign wr_gate   = accept && i_avs_write && (i_avs_address == `GST_IDX_GATE) && i_avs_byteenable[0];
    assign wr_low    = accept && i_avs_write && (i_avs_address == `GST_IDX_COUNT_LOW) && i_avs_byteenable[0];
    assign wr_high   = accept && i_avs_write && (i_avs_address == `GST_IDX_COUNT_HIGH) && i_avs_byteenable[0];
    assign cnt_wr    = wr_low || wr_high;
    assign rd_status = accept && i_avs_read && (i_avs_address == `GST_IDX_STATUS);
    // A read clears only a flag that its own snapshot returned, so an overflow between snapshot and clear is kept.
    assign status_clr = rd_status && rdata_reg[`GST_STAT_OVF];

    // Each counter byte loads from its own write; a write wins over an increment, so a
    // write into a running timer leaves a value software cannot predict.
    always_comb begin
        count_next = inc ? count_reg + 16'h0001 : count_reg;
        for (int b = 0; b < 2; b++) begin
            if ((b == 0) ? wr_low : wr_high) begin
                count_next[b*8 +: 8] = i_avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `GST_COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // Control registers start cleared, so the timer is off after reset.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `GST_CTRL_RESET;
            gate_reg <= `GST_GATE_RESET;
            mask_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.on       <= i_avs_writedata[`GST_CTRL_ON];
                ctrl_reg.sync_dis <= i_avs_writedata[`GST_CTRL_SYNC_DIS];
                ctrl_reg.prescale <= i_avs_writedata[`GST_CTRL_PRE_HI:`GST_CTRL_PRE_LO];
                ctrl_reg.source   <= gst_pkg::gst_src_t'(i_avs_writedata[`GST_CTRL_SRC_HI:`GST_CTRL_SRC_LO]);
            end
            if (wr_gate) begin
                gate_reg.enable     <= i_avs_writedata[`GST_GATE_EN];
                gate_reg.polarity   <= i_avs_writedata[`GST_GATE_POL];
                gate_reg.source_sel <= i_avs_writedata[`GST_GATE_SEL];
            end
            if (accept && i_avs_write && (i_avs_address == `GST_IDX_MASK) && i_avs_byteenable[0]) begin
                mask_reg <= i_avs_writedata[`GST_STAT_OVF];
            end
        end
    end

    // Overflow flag: a new overflow wins over the clearing read.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 1'b0;
        end else if (ovf) begin
            status_reg <= 1'b1;
        end else if (status_clr) begin
            status_reg <= 1'b0;
        end
    end

    // Interrupt level, and a wake pulse for an overflow counted while asleep.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg  <= (ovf || (status_reg && !status_clr)) && mask_reg;
            wake_reg <= ovf && i_sleep && mask_reg;
        end
    end

    // Read data; the count is one registered word, so each byte read is a clean
    // snapshot even when the source is asynchronous to the bus.
    always_comb begin
        rdata_next = `GST_RDATA_ZERO;
        unique case (i_avs_address)
            `GST_IDX_CTRL: begin
                rdata_next[`GST_CTRL_ON]                           = ctrl_reg.on;
                rdata_next[`GST_CTRL_SYNC_DIS]                     = ctrl_reg.sync_dis;
                rdata_next[`GST_CTRL_PRE_HI:`GST_CTRL_PRE_LO]      = ctrl_reg.prescale;
                rdata_next[`GST_CTRL_SRC_HI:`GST_CTRL_SRC_LO]      = ctrl_reg.source;
            end
            `GST_IDX_GATE: begin
                rdata_next[`GST_GATE_EN]  = gate_reg.enable;
                rdata_next[`GST_GATE_POL] = gate_reg.polarity;
                rdata_next[`GST_GATE_SEL] = gate_reg.source_sel;
            end
            `GST_IDX_COUNT_LOW:  rdata_next[7:0] = count_reg[7:0];
            `GST_IDX_COUNT_HIGH: rdata_next[7:0] = count_reg[15:8];
            `GST_IDX_STATUS:     rdata_next[`GST_STAT_OVF] = status_reg;
            `GST_IDX_MASK:       rdata_next[`GST_STAT_OVF] = mask_reg;
            default:             rdata_next = `GST_RDATA_ZERO;
        endcase
    end

    // Waitrequest is high at rest and drops for exactly one cycle per request.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= `GST_RDATA_ZERO;
        end else begin
            wait_reg <= !take_req;
            if (take_req) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign o_avs_readdata    = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_irq             = irq_reg;
    assign o_wake            = wake_reg;

    assign sys_full = ctrl_reg.on && !gate_reg.enable && ctrl_reg.prescale == 2'h0 && !i_sleep
                      && ctrl_reg.source == gst_pkg::GST_SRC_SYSTEM && !cnt_wr;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    off_holds_a: assert property (!ctrl_reg.on && !cnt_wr |=> count_reg == $past(count_reg))
        else $error("Count moved while the timer was off.");

    byte_load_a: assert property (wr_low |=> count_reg[7:0] == $past(i_avs_writedata[7:0]))
        else $error("Low count byte did not load the written value.");

    presc_clear_a: assert property (cnt_wr |=> pre_reg == `GST_PRE_ZERO)
        else $error("Prescale counter not cleared by a count write.");

    gate_hold_a: assert property (gate_reg.enable && !gate_active && !cnt_wr |=> $stable(count_reg))
        else $error("Count moved while the gate was inactive.");

    wrap_flag_a: assert property (ovf |=> status_reg && count_reg == `GST_COUNT_RESET)
        else $error("Rollover did not clear the count and set the flag.");

    instr_rate_a: assert property (inc && ctrl_reg.source == gst_pkg::GST_SRC_INSTR |-> instr_tick)
        else $error("Instruction source counted off the instruction phase.");

    ext_arm_a: assert property (inc && ctrl_reg.source == gst_pkg::GST_SRC_EXT |-> armed_reg)
        else $error("External count taken before a falling edge.");

    sys_rate_a: assert property (sys_full [*4] |=> count_reg == $past(count_reg, 4) + 16'h0004)
        else $error("System clock source did not advance four per instruction cycle.");

    presc_rate_a: assert property (inc && ctrl_reg.prescale == 2'h3 |-> pre_reg == 3'h7)
        else $error("Divide by eight stepped at the wrong prescale count.");

    irq_level_a: assert property (status_reg && mask_reg && !rd_status |=> irq_reg)
        else $error("Interrupt low while an unmasked overflow flag was set.");

    wake_pulse_a: assert property (wake_reg |-> irq_reg)
        else $error("Wake pulse without the overflow interrupt.");

    wait_pulse_a: assert property (!wait_reg |=> wait_reg)
        else $error("Waitrequest stayed low for more than one cycle.");

    async_sleep_a: assert property (ctrl_reg.on && !gate_reg.enable && ctrl_reg.sync_dis
        && ctrl_reg.prescale == 2'h0 && ctrl_reg.source == gst_pkg::GST_SRC_EXT
        && ext_rise && armed_reg && !cnt_wr |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Asynchronous external edge was not counted.");

    gate_wrap_a: assert property (ctrl_reg.on && gate_reg.enable && gate_reg.source_sel
        && gate_reg.polarity && !i_byte_timer_wrap_pulse && !cnt_wr |=> $stable(count_reg))
        else $error("Count moved between byte timer wrap pulses.");

endmodule : gst_timer

`default_nettype wire

/* File: verification/gst_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none

module gst_pins_model (
    // Clock and commands
    input  wire logic i_clock,
    input  wire logic i_ext_idle,
    input  wire logic i_gate_level,
    // Pins
    output logic      o_external_clock_pin,
    output logic      o_gate_pin,
    output logic      o_low_freq_internal_osc,
    output logic      o_byte_timer_wrap_pulse
);
    // Tasks only raise the goals and the clocked block only advances the done counts,
    // so every variable has a single writer.
    logic [2:0] phase     = 3'h0;
    logic [2:0] osc_div   = 3'h0;
    logic       ext_q     = 1'b1;
    logic       gate_q    = 1'b0;
    logic       osc_q     = 1'b0;
    logic       wrap_q    = 1'b0;
    int         ext_goal  = 0;
    int         ext_done  = 0;
    int         wrap_goal = 0;
    int         wrap_done = 0;

    assign o_external_clock_pin    = ext_q;
    assign o_gate_pin              = gate_q;
    assign o_low_freq_internal_osc = osc_q;
    assign o_byte_timer_wrap_pulse = wrap_q;

    // External clock edges are six clocks apart and oscillator edges eight, so both synchronised paths see every level.
    always @(posedge i_clock) begin
        phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
        osc_div <= osc_div + 3'h1;
        if (osc_div == 3'h7) begin
            osc_q <= ~osc_q;
        end
        gate_q <= i_gate_level;
        wrap_q <= (wrap_done < wrap_goal) && (phase == 3'h0);
        if ((wrap_done < wrap_goal) && (phase == 3'h0)) begin
            wrap_done <= wrap_done + 1;
        end
        if (ext_done == ext_goal) begin
            ext_q <= i_ext_idle;
        end else if (phase == 3'h5) begin
            ext_q <= ~ext_q;
            ext_done <= ext_done + 1;
        end
    end

    task automatic ext_pulses(input int n);
        ext_goal = ext_goal + 2 * n;
        wait (ext_done == ext_goal);
    endtask : ext_pulses

    task automatic wrap_pulses(input int n);
        wrap_goal = wrap_goal + n;
        wait (wrap_done == wrap_goal);
    endtask : wrap_pulses
endmodule : gst_pins_model

`default_nettype wire

/* File: verification/gst_timer_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gst_consts.svh"

module gst_timer_bench;
    logic        i_clock;
    logic        rst_n;
    logic [2:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        sleep;
    logic        ext_idle;
    logic        gate_level;
    logic [31:0] rdata;
    logic        waitreq;
    logic        ext_pin, gate_pin, lf_osc, wrap, irq, wake;
    int          bad_count, n_tests, cycles, wake_n;
    logic [31:0] rv;
    logic [15:0] cnt;

    gst_timer dut (.i_clock(i_clock), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_external_clock_pin(ext_pin), .i_gate_pin(gate_pin),
        .i_low_freq_internal_osc(lf_osc), .i_byte_timer_wrap_pulse(wrap), .i_sleep(sleep),
        .o_irq(irq), .o_wake(wake));

    gst_pins_model pins (.i_clock(i_clock), .i_ext_idle(ext_idle), .i_gate_level(gate_level),
        .o_external_clock_pin(ext_pin), .o_gate_pin(gate_pin), .o_low_freq_internal_osc(lf_osc),
        .o_byte_timer_wrap_pulse(wrap));

    initial i_clock = 1'b0;
    always #12.5 i_clock = ~i_clock;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // The request is held until the edge that samples waitrequest low.
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= {24'h0, d};
        do begin
            @(posedge i_clock);
        end while (waitreq !== 1'b0);
        rv = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : access

    task automatic run_count(input logic [15:0] start, input logic [7:0] ctrl, input int wait_n,
                             input int ext, input int wraps);
        access(1'b1, `GST_IDX_COUNT_LOW, start[7:0]);
        access(1'b1, `GST_IDX_COUNT_HIGH, start[15:8]);
        access(1'b1, `GST_IDX_CTRL, ctrl);
        pins.ext_pulses(ext);
        pins.wrap_pulses(wraps);
        repeat (wait_n) @(posedge i_clock);
        access(1'b1, `GST_IDX_CTRL, 8'h00);
        access(1'b0, `GST_IDX_COUNT_LOW, 8'h00);
        cnt[7:0] = rv[7:0];
        access(1'b0, `GST_IDX_COUNT_HIGH, 8'h00);
        cnt[15:8] = rv[7:0];
    endtask : run_count

    always @(posedge i_clock) begin
        cycles++;
        if (wake === 1'b1)
            wake_n++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        {addr, rd, wr, wdata, sleep, gate_level, cnt, rv} = '0;
        be = 4'hf;
        ext_idle = 1'b1;
        {bad_count, n_tests, cycles, wake_n} = '0;
        repeat (8) @(posedge i_clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        check("irq after reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            access(1'b0, 3'(i), 8'h00);
            check("reset read", rv, 32'h0);
        end
        access(1'b1, `GST_IDX_CTRL, 8'hfe);
        access(1'b0, `GST_IDX_CTRL, 8'h00);
        check("ctrl fields", rv, 32'hf4);
        access(1'b1, `GST_IDX_GATE, 8'hff);
        access(1'b0, `GST_IDX_GATE, 8'h00);
        check("gate fields", rv, 32'hd0);
        access(1'b1, `GST_IDX_GATE, 8'h00);
        be <= 4'he;
        access(1'b1, `GST_IDX_COUNT_LOW, 8'h5a);
        be <= 4'hf;
        access(1'b0, `GST_IDX_COUNT_LOW, 8'h00);
        check("byte enable", rv, 32'h0);
        access(1'b1, 3'h7, 8'hff);
        access(1'b0, 3'h7, 8'h00);
        check("unmapped", rv, 32'h0);
        run_count(16'ha55a, 8'h40, 40, 0, 0);
        check("count held off", {16'h0, cnt}, 32'ha55a);
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                run_count(16'h0, {1'b0, s[0], p[1:0], 4'h1}, 128, 0, 0);
                check("internal rate", {31'h0, cnt >= (128 >> (p + 2 - 2 * s)) - 1
                      && cnt <= (136 >> (p + 2 - 2 * s)) + 1}, 32'h1);
            end
        end
        run_count(16'h0, 8'hc1, 256, 0, 0);
        check("slow osc", {31'h0, cnt >= 14 && cnt <= 18}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            ext_idle <= k[0];
            run_count(16'h0, {5'h10, k[1], 2'h1}, 10, 5, 0);
            check("ext edges", {16'h0, cnt}, 32'd4 + k[0]);
        end
        access(1'b1, `GST_IDX_MASK, 8'h00);
        run_count(16'hfff0, 8'h41, 32, 0, 0);
        check("masked irq", {31'h0, irq}, 32'h0);
        check("rollover", {24'h0, cnt[15:8]}, 32'h0);
        access(1'b1, `GST_IDX_MASK, 8'h01);
        repeat (2) @(posedge i_clock);
        check("irq", {31'h0, irq}, 32'h1);
        access(1'b0, `GST_IDX_STATUS, 8'h00);
        check("flag", rv, 32'h1);
        repeat (2) @(posedge i_clock);
        check("irq cleared", {31'h0, irq}, 32'h0);
        access(1'b0, `GST_IDX_STATUS, 8'h00);
        check("flag cleared", rv, 32'h0);
        sleep <= 1'b1;
        ext_idle <= 1'b1;
        run_count(16'hfffe, 8'h85, 10, 3, 0);
        sleep <= 1'b0;
        check("sleep count", {16'h0, cnt}, 32'h1);
        check("wake pulses", wake_n, 32'h1);
        access(1'b0, `GST_IDX_STATUS, 8'h00);
        for (int g = 0; g < 4; g++) begin
            gate_level <= g[0];
            access(1'b1, `GST_IDX_GATE, {1'b1, g[1], 6'h0});
            run_count(16'h0, 8'h41, 64, 0, 0);
            check("gate pin", {31'h0, (g[0] == g[1]) ? (cnt >= 60 && cnt <= 72)
                  : (cnt == 16'h0)}, 32'h1);
        end
        access(1'b1, `GST_IDX_GATE, 8'hd0);
        run_count(16'h0, 8'h41, 4, 0, 3);
        check("wrap gate", {16'h0, cnt}, 32'h3);
        print_verdict();
    end
endmodule : gst_timer_bench

`default_nettype wire
